// >>> hw/dcst_params.svh
// Timing, width and reset constants for the duty-cycle serial transmitter.
`ifndef DCST_PARAMS_SVH
`define DCST_PARAMS_SVH
`define DCST_CLK_PERIOD_NS 5
`define DCST_BIT_PERIOD_NS 5000
`define DCST_BIT_CYCLES (`DCST_BIT_PERIOD_NS / `DCST_CLK_PERIOD_NS)
`define DCST_ZERO_CYCLES ((`DCST_BIT_CYCLES * 1) / 5)
`define DCST_ONE_CYCLES (((`DCST_BIT_CYCLES * 4) + 4) / 5)
`define DCST_DONE_PULSE_NS 125
`define DCST_DONE_CYCLES (`DCST_DONE_PULSE_NS / `DCST_CLK_PERIOD_NS)
`define DCST_PAT_BITS 16
`define DCST_PKT_LEN_DEF 5'h08
`define DCST_PAT_RESET 16'h0000
`define DCST_CNT_W 11
`define DCST_LEN_W 5
`endif

// >>> hw/dcst_pkg.sv
// Types shared by the duty-cycle serial transmitter.
package dcst_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_DONE} dcst_state_t;
  typedef struct packed {
    logic [15:0] pattern;
    logic [4:0] length;
  } dcst_load_t;
endpackage : dcst_pkg

// >>> hw/dcst_tx.sv
// Duty-cycle serial transmitter with pattern source, packet counter and burst mode.
// Notes on behaviour
// [R01] Each bit is one period of a pulse; only its high time carries the value.
// [R02] Zero bit high at most one fifth; one bit high at least four fifths.
// [R03] Other thresholds allowed if zero and one high times stay well apart.
// [R04] A packet starts only when pin enable or host enable bit is set, or on a trigger rising edge.
// [R05] A bit period timer makes the tick; each bit lasts one tick interval.
// [R06] Separate zero and one width timers restart at every bit period start.
// [R07] Pattern loads from host writes or from a power-up configuration value.
// [R08] Pattern holds sixteen bits; reference packet sends eight of them.
// [R09] Packet length counter ends transmission after the configured bit count.
// [R10] Each period the selector drives zero or one pulse from the pattern bit.
// [R11] Host may rewrite the pattern after a packet has finished.
// [R12] Packet completion raises a pulse on the interrupt output.
// [R13] Pattern bits are presented one at a time in order.
// [R14] Trigger rising edge emits the full sixteen-bit pattern once; the code sends the configured length instead if enable is set at the edge.
// [R15] Burst window one-shot is loaded with pattern length minus one.
// [R16] Companion one-shot is loaded with pattern length minus two.
// [R17] The receiver samples half a bit period after each rising edge.
// [R18] Without enable outside a trigger burst, or under reset, the line is low and counters are zero.
`timescale 1ns/1ps
`include "dcst_params.svh"
module dcst_tx (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic enable_pin_i,
  input wire logic enable_host_i,
  input wire logic trigger_i,
  input wire logic load_i,
  input wire dcst_pkg::dcst_load_t load_data_i,
  input wire logic [15:0] nv_pattern_i,
  output logic load_ready_o,
  output logic line_o,
  output logic done_pulse_o,
  output logic busy_o,
  output logic burst_window_o,
  output logic burst_companion_o
);
  // Outside pins pass two flip-flops before use.
  logic [1:0] en_sync_reg;
  logic [1:0] trig_sync_reg;
  logic trig_prev_reg;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      en_sync_reg <= 2'h0;
      trig_sync_reg <= 2'h0;
      trig_prev_reg <= 1'b0;
    end else if (ce_i) begin
      en_sync_reg <= {en_sync_reg[0], enable_pin_i};
      trig_sync_reg <= {trig_sync_reg[0], trigger_i};
      trig_prev_reg <= trig_sync_reg[1];
    end
  end
  logic enable_w;
  logic trig_rise_w;
  assign enable_w = en_sync_reg[1] | enable_host_i; // R04
  assign trig_rise_w = trig_sync_reg[1] & ~trig_prev_reg; // R14

  // Two-entry load buffer so up to two loads during a packet wait rather than being lost.
  dcst_pkg::dcst_load_t buf_reg [2];
  dcst_pkg::dcst_load_t buf_next [2];
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic pop_w;
  always_comb begin
    buf_next = buf_reg;
    cnt_next = cnt_reg;
    if (pop_w) begin
      buf_next[0] = buf_reg[1];
      cnt_next = cnt_next - 2'h1;
    end
    if (load_i && cnt_reg != 2'h2) begin
      buf_next[cnt_next[0]] = load_data_i;
      cnt_next = cnt_next + 2'h1;
    end
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      buf_reg[0] <= '0;
      buf_reg[1] <= '0;
      cnt_reg <= 2'h0;
      load_ready_o <= 1'b0;
    end else if (ce_i) begin
      buf_reg <= buf_next;
      cnt_reg <= cnt_next;
      load_ready_o <= (cnt_next != 2'h2);
    end
  end

  // Main transmit state.
  dcst_pkg::dcst_state_t state_reg;
  dcst_pkg::dcst_state_t state_next;
  logic [15:0] pat_reg;
  logic [15:0] pat_next;
  logic [15:0] shift_reg;
  logic [15:0] shift_next;
  logic [4:0] len_reg;
  logic [4:0] len_next;
  logic [`DCST_LEN_W-1:0] bits_reg;
  logic [`DCST_LEN_W-1:0] bits_next;
  logic [`DCST_CNT_W-1:0] period_reg;
  logic [`DCST_CNT_W-1:0] period_next;
  logic [`DCST_CNT_W-1:0] zero_reg;
  logic [`DCST_CNT_W-1:0] zero_next;
  logic [`DCST_CNT_W-1:0] one_reg;
  logic [`DCST_CNT_W-1:0] one_next;
  logic [`DCST_LEN_W-1:0] win_reg;
  logic [`DCST_LEN_W-1:0] win_next;
  logic [`DCST_LEN_W-1:0] comp_reg;
  logic [`DCST_LEN_W-1:0] comp_next;
  logic [5:0] done_reg;
  logic [5:0] done_next;
  logic line_next;
  logic burst_reg;
  logic burst_next;
  logic nv_loaded_reg;
  logic tick_w;

  assign tick_w = (period_reg == `DCST_CNT_W'(`DCST_BIT_CYCLES - 1)); // R05
  assign pop_w = (state_reg == dcst_pkg::ST_IDLE) && (cnt_reg != 2'h0) && nv_loaded_reg; // R11

  always_comb begin
    state_next = state_reg;
    pat_next = pat_reg;
    shift_next = shift_reg;
    len_next = len_reg;
    bits_next = bits_reg;
    period_next = period_reg;
    zero_next = zero_reg;
    one_next = one_reg;
    win_next = win_reg;
    comp_next = comp_reg;
    done_next = (done_reg != 6'h00) ? done_reg - 6'h01 : 6'h00;
    burst_next = burst_reg;
    line_next = 1'b0;
    if (!nv_loaded_reg) begin
      pat_next = nv_pattern_i; // R07
    end else if (pop_w) begin
      pat_next = buf_reg[0].pattern; // R07
      len_next = buf_reg[0].length;
    end
    case (state_reg)
      dcst_pkg::ST_IDLE: begin
        bits_next = '0; // R18
        period_next = '0;
        if (nv_loaded_reg && !pop_w && (enable_w || trig_rise_w)) begin
          state_next = dcst_pkg::ST_SEND;
          shift_next = pat_reg;
          burst_next = trig_rise_w && !enable_w; // R14
          win_next = `DCST_LEN_W'(`DCST_PAT_BITS - 1); // R15
          comp_next = `DCST_LEN_W'(`DCST_PAT_BITS - 2); // R16
          zero_next = '0; // R06
          one_next = '0;
        end
      end
      dcst_pkg::ST_SEND: begin
        if (!enable_w && !burst_reg) begin
          state_next = dcst_pkg::ST_IDLE; // R18
          bits_next = '0;
          // An abort on the tick cycle would otherwise leave the period timer at its end value.
          period_next = '0; // R18
          zero_next = '0;
          one_next = '0;
        end else begin
          // Line high while the selected width timer is still running.
          line_next = shift_reg[15] ? (one_reg < `DCST_CNT_W'(`DCST_ONE_CYCLES))
                                    : (zero_reg < `DCST_CNT_W'(`DCST_ZERO_CYCLES)); // R02 R03 R10
          period_next = tick_w ? '0 : period_reg + `DCST_CNT_W'(1); // R01
          zero_next = tick_w ? '0 : zero_reg + `DCST_CNT_W'(1); // R06
          one_next = tick_w ? '0 : one_reg + `DCST_CNT_W'(1); // R06
          if (tick_w) begin
            shift_next = {shift_reg[14:0], 1'b0}; // R13
            bits_next = bits_reg + `DCST_LEN_W'(1); // R09
            if (burst_reg) begin
              win_next = (win_reg != '0) ? win_reg - `DCST_LEN_W'(1) : '0; // R15
              comp_next = (comp_reg != '0) ? comp_reg - `DCST_LEN_W'(1) : '0; // R16
            end
            if (bits_next == (burst_reg ? `DCST_LEN_W'(`DCST_PAT_BITS) : len_reg)) begin
              state_next = dcst_pkg::ST_DONE; // R09
              done_next = 6'(`DCST_DONE_CYCLES); // R12
            end
          end
        end
      end
      dcst_pkg::ST_DONE: begin
        // Wait for enable to drop so one enable level sends a single packet.
        bits_next = '0;
        burst_next = 1'b0;
        if (!enable_w) begin
          state_next = dcst_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = dcst_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= dcst_pkg::ST_IDLE;
      pat_reg <= `DCST_PAT_RESET;
      shift_reg <= `DCST_PAT_RESET;
      len_reg <= `DCST_PKT_LEN_DEF; // R08
      bits_reg <= '0;
      period_reg <= '0;
      zero_reg <= '0;
      one_reg <= '0;
      win_reg <= '0;
      comp_reg <= '0;
      done_reg <= 6'h00;
      burst_reg <= 1'b0;
      nv_loaded_reg <= 1'b0;
      line_o <= 1'b0;
      done_pulse_o <= 1'b0;
      busy_o <= 1'b0;
      burst_window_o <= 1'b0;
      burst_companion_o <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      pat_reg <= pat_next;
      shift_reg <= shift_next;
      len_reg <= len_next;
      bits_reg <= bits_next;
      period_reg <= period_next;
      zero_reg <= zero_next;
      one_reg <= one_next;
      win_reg <= win_next;
      comp_reg <= comp_next;
      done_reg <= done_next;
      burst_reg <= burst_next;
      nv_loaded_reg <= 1'b1;
      line_o <= line_next;
      done_pulse_o <= (done_next != 6'h00); // R12
      busy_o <= (state_next == dcst_pkg::ST_SEND);
      burst_window_o <= burst_next && (state_next == dcst_pkg::ST_SEND) && (win_next != '0);
      burst_companion_o <= burst_next && (state_next == dcst_pkg::ST_SEND) && (comp_next != '0);
    end
  end

  // Checks.
  line_low_idle_a: assert property (@(posedge clock_i) disable iff (rst_i) // R18
    (ce_i && state_reg == dcst_pkg::ST_IDLE) |=> !line_o)
    else $error("line high while idle");
  zero_width_a: assert property (@(posedge clock_i) disable iff (rst_i) // R02
    (ce_i && state_reg == dcst_pkg::ST_SEND && !shift_reg[15] && enable_w
     && zero_reg >= 11'(`DCST_ZERO_CYCLES)) |=> !line_o)
    else $error("zero pulse too long");
  one_width_a: assert property (@(posedge clock_i) disable iff (rst_i) // R02
    (ce_i && state_reg == dcst_pkg::ST_SEND && shift_reg[15] && enable_w
     && one_reg < 11'(`DCST_ONE_CYCLES)) |=> line_o)
    else $error("one pulse too short");
  period_wrap_a: assert property (@(posedge clock_i) disable iff (rst_i) // R05
    (ce_i && tick_w && state_reg == dcst_pkg::ST_SEND) |=> (period_reg == '0))
    else $error("period timer did not wrap");
  timers_restart_a: assert property (@(posedge clock_i) disable iff (rst_i) // R06
    (ce_i && tick_w && state_reg == dcst_pkg::ST_SEND) |=> (zero_reg == '0 && one_reg == '0))
    else $error("width timers not restarted");
  start_needs_en_a: assert property (@(posedge clock_i) disable iff (rst_i) // R04
    (ce_i && state_reg == dcst_pkg::ST_IDLE && !enable_w && !trig_rise_w)
    |=> state_reg != dcst_pkg::ST_SEND)
    else $error("packet started without enable");
  done_pulse_a: assert property (@(posedge clock_i) disable iff (rst_i) // R12
    (ce_i && state_reg == dcst_pkg::ST_SEND && state_next == dcst_pkg::ST_DONE) |=> done_pulse_o)
    else $error("no completion pulse");
  pkt_count_a: assert property (@(posedge clock_i) disable iff (rst_i) // R09
    (state_reg == dcst_pkg::ST_SEND && !burst_reg) |-> bits_reg < len_reg)
    else $error("packet overran its length");
  burst_load_a: assert property (@(posedge clock_i) disable iff (rst_i) // R15
    (ce_i && state_reg == dcst_pkg::ST_IDLE && state_next == dcst_pkg::ST_SEND)
    |=> (win_reg == 5'(`DCST_PAT_BITS - 1) && comp_reg == 5'(`DCST_PAT_BITS - 2)))
    else $error("burst one-shots loaded wrong");
  abort_zero_a: assert property (@(posedge clock_i) disable iff (rst_i) // R18
    (ce_i && state_reg == dcst_pkg::ST_SEND && !enable_w && !burst_reg)
    |=> (!line_o && bits_reg == '0 && period_reg == '0))
    else $error("abort left line or counters active");
  burst_sixteen_a: assert property (@(posedge clock_i) disable iff (rst_i) // R14
    (state_reg == dcst_pkg::ST_SEND && burst_reg) |-> (bits_reg < 5'(`DCST_PAT_BITS)))
    else $error("burst overran the pattern");
  ce_freeze_a: assert property (@(posedge clock_i) disable iff (rst_i) // R18
    (!ce_i) |=> ($stable(line_o) && $stable(state_reg) && $stable(bits_reg)))
    else $error("state moved while clock enable low");

  // Helper count of completion pulse length, used by the checks below only.
  logic [5:0] dlen_reg;
  logic [5:0] dlen_next;
  always_comb begin
    dlen_next = done_pulse_o ? dlen_reg + 6'h01 : 6'h00;
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      dlen_reg <= 6'h00;
    end else if (ce_i) begin
      dlen_reg <= dlen_next;
    end
  end
  done_long_a: assert property (@(posedge clock_i) disable iff (rst_i) // R12
    (ce_i && done_pulse_o) |-> (dlen_reg < 6'(`DCST_DONE_CYCLES)))
    else $error("completion pulse too long");
  done_short_a: assert property (@(posedge clock_i) disable iff (rst_i) // R12
    (ce_i && !done_pulse_o && dlen_reg != 6'h00) |-> (dlen_reg == 6'(`DCST_DONE_CYCLES)))
    else $error("completion pulse too short");
  send_c: cover property (@(posedge clock_i) state_reg == dcst_pkg::ST_SEND ##1
    state_reg == dcst_pkg::ST_DONE);
  burst_c: cover property (@(posedge clock_i) burst_reg && state_reg == dcst_pkg::ST_DONE);
  reload_c: cover property (@(posedge clock_i) pop_w);
  stall_c: cover property (@(posedge clock_i) !load_ready_o);
  abort_c: cover property (@(posedge clock_i) state_reg == dcst_pkg::ST_SEND ##1
    state_reg == dcst_pkg::ST_IDLE);
endmodule : dcst_tx

// >>> dv/dcst_rx_model.sv
// Behavioural single-wire receiver that samples each bit mid-period.
`timescale 1ns/1ps
module dcst_rx_model #(
  parameter int HALF = 500,
  parameter int REPORT = 900
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic line_i,
  output logic rx_valid_o,
  output logic rx_bit_o,
  output logic [10:0] rx_high_o
);
  logic prev_reg;
  logic bit_reg;
  logic [10:0] age_reg;
  logic [10:0] hi_reg;
  // Age saturates, so an idle line never yields a spurious report.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prev_reg <= 1'b0;
      bit_reg <= 1'b0;
      age_reg <= 11'h7ff;
      hi_reg <= 11'h000;
      rx_valid_o <= 1'b0;
    end else begin
      prev_reg <= line_i;
      rx_valid_o <= (age_reg == 11'(REPORT));
      if (line_i && !prev_reg) begin
        age_reg <= 11'h001;
        hi_reg <= 11'h001;
      end else begin
        if (age_reg != 11'h7ff) age_reg <= age_reg + 11'h001;
        if (line_i) hi_reg <= hi_reg + 11'h001;
      end
      if (age_reg == 11'(HALF)) bit_reg <= line_i;
    end
  end
  assign rx_bit_o = bit_reg;
  assign rx_high_o = hi_reg;
endmodule : dcst_rx_model

// >>> dv/dcst_tb_top.sv
// Self-checking bench for the duty-cycle serial transmitter.
`timescale 1ns/1ps
module duty_cycle_serial_transmitter_tb_top;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic en_pin = 1'b0;
  logic en_host = 1'b0;
  logic trig = 1'b0;
  logic load = 1'b0;
  logic mute = 1'b0;
  logic ce = 1'b1;
  logic exp_bit;
  dcst_pkg::dcst_load_t ld = '0;
  logic [15:0] nv = 16'h0000;
  logic [15:0] pat_b;
  logic [4:0] len_b;
  logic ready, line, done, busy, bwin, bcomp, rx_valid, rx_bit;
  logic [10:0] rx_high;
  logic exp_q[$];
  int err_total = 0;
  int check_count = 0;
  initial forever #2.5 clock_i = ~clock_i;
  dcst_tx i_dut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce), .enable_pin_i(en_pin),
    .enable_host_i(en_host), .trigger_i(trig), .load_i(load), .load_data_i(ld),
    .nv_pattern_i(nv), .load_ready_o(ready), .line_o(line), .done_pulse_o(done),
    .busy_o(busy), .burst_window_o(bwin), .burst_companion_o(bcomp));
  dcst_rx_model i_rx (.clock_i(clock_i), .rst_i(rst_i), .line_i(line),
    .rx_valid_o(rx_valid), .rx_bit_o(rx_bit), .rx_high_o(rx_high));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("Counts: %0d checks, %0d mismatches", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc
  task automatic hang();
    err_total++;
    $display("ERROR %0t: wait ran out", $time);
    final_report();
  endtask : hang
  task automatic note(input logic [15:0] p, input logic [4:0] l);
    for (int i = 0; i < int'(l); i++) exp_q.push_back(p[15 - i]);
  endtask : note
  task automatic push(input logic [15:0] p, input logic [4:0] l);
    int n;
    n = 0;
    load <= 1'b1;
    ld <= '{pattern: p, length: l};
    cyc(1);
    while (ready !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    if (n >= 100) hang();
    load <= 1'b0;
  endtask : push
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 20000) hang();
    end
    n = 0;
    while (done === 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    if (n >= 100) hang();
    chk(n, 25);
  endtask : wait_done
  // Each reported bit outside the mute window must match the oldest noted bit and its exact high time.
  always @(posedge clock_i) begin
    if (rx_valid === 1'b1 && mute !== 1'b1) begin
      if (exp_q.size() == 0) chk(1, 0);
      else begin
        exp_bit = exp_q.pop_front();
        chk(rx_bit, exp_bit);
        chk(32'(rx_high), exp_bit ? 32'h320 : 32'h0c8);
      end
    end
  end
  initial begin
    void'($urandom(11));
    nv <= 16'($urandom);
    cyc(16);
    rst_i <= 1'b0;
    cyc(2);
    chk(line, 0);
    chk(ready, 1);
    $display("Test reset done");
    note(nv, 5'h08);
    en_host <= 1'b1;
    cyc(100);
    chk(busy, 1);
    pat_b = 16'($urandom);
    len_b = 5'(32'h1 + $urandom % 5);
    push(16'($urandom), 5'h10);
    cyc(1);
    push(pat_b, len_b);
    cyc(1);
    load <= 1'b1;
    ld <= '{pattern: ~pat_b, length: 5'h02};
    cyc(1);
    chk(ready, 0);
    load <= 1'b0;
    wait_done();
    en_host <= 1'b0;
    cyc(20);
    chk(ready, 1);
    $display("Test host packet done");
    note(pat_b, len_b);
    en_pin <= 1'b1;
    wait_done();
    en_pin <= 1'b0;
    cyc(20);
    $display("Test pin packet done");
    note(pat_b, 5'h10);
    trig <= 1'b1;
    cyc(10);
    chk(bwin, 1);
    chk(bcomp, 1);
    trig <= 1'b0;
    cyc(17000);
    chk(busy, 0);
    chk(exp_q.size(), 0);
    $display("Test burst done");
    push(16'hffff, 5'h08);
    cyc(5);
    en_host <= 1'b1;
    cyc(300);
    mute <= 1'b1;
    en_host <= 1'b0;
    cyc(4);
    chk(line, 0);
    chk(busy, 0);
    cyc(1500);
    mute <= 1'b0;
    $display("Test abort done");
    ce <= 1'b0;
    en_host <= 1'b1;
    cyc(50);
    chk(busy, 0);
    chk(line, 0);
    en_host <= 1'b0;
    ce <= 1'b1;
    cyc(4);
    chk(busy, 0);
    $display("Test freeze done");
    final_report();
  end
endmodule : duty_cycle_serial_transmitter_tb_top
